// File: logic/reader_regs_pkg.sv
package reader_regs_pkg;

  // register offsets, page 0
  localparam logic [5:0] ADDR_PAGE_SELECT_P0       = 6'h00;
  localparam logic [5:0] ADDR_COMMAND_REG          = 6'h01;
  localparam logic [5:0] ADDR_BUFFER_ACCESS_PORT   = 6'h02;
  localparam logic [5:0] ADDR_MAIN_STATUS          = 6'h03;
  localparam logic [5:0] ADDR_BUFFER_FILL_COUNT    = 6'h04;
  localparam logic [5:0] ADDR_EXTRA_STATUS         = 6'h05;
  localparam logic [5:0] ADDR_IRQ_ENABLE_BITS      = 6'h06;
  localparam logic [5:0] ADDR_IRQ_REQUEST_FLAGS    = 6'h07;
  // page 1
  localparam logic [5:0] ADDR_PAGE_SELECT_P1       = 6'h08;
  localparam logic [5:0] ADDR_CONTROL              = 6'h09;
  localparam logic [5:0] ADDR_LAST_COMMAND_ERRORS  = 6'h0A;
  localparam logic [5:0] ADDR_COLLISION_BIT_INDEX  = 6'h0B;
  localparam logic [5:0] ADDR_TIMER_COUNT_NOW      = 6'h0C;
  localparam logic [5:0] ADDR_CHECKSUM_RESULT_LOW  = 6'h0D;
  localparam logic [5:0] ADDR_CHECKSUM_RESULT_HIGH = 6'h0E;
  localparam logic [5:0] ADDR_PARTIAL_FRAME_ADJUST = 6'h0F;
  // page 2
  localparam logic [5:0] ADDR_PAGE_SELECT_P2       = 6'h10;
  localparam logic [5:0] ADDR_ANTENNA_DRIVER_CTRL  = 6'h11;
  localparam logic [5:0] ADDR_DRIVER_CONDUCTANCE   = 6'h12;
  localparam logic [5:0] ADDR_FIXED_PRESET_A       = 6'h13;
  localparam logic [5:0] ADDR_FIXED_PRESET_B       = 6'h14;
  localparam logic [5:0] ADDR_PULSE_WIDTH_SEL      = 6'h15;
  localparam logic [5:0] ADDR_FIXED_PRESET_C       = 6'h16;
  localparam logic [5:0] ADDR_FIXED_PRESET_D       = 6'h17;
  // page 3
  localparam logic [5:0] ADDR_PAGE_SELECT_P3       = 6'h18;
  localparam logic [5:0] ADDR_RECEIVER_CTRL_A      = 6'h19;
  localparam logic [5:0] ADDR_DECODING_CTRL        = 6'h1A;
  localparam logic [5:0] ADDR_RX_TX_PHASE_SEL      = 6'h1B;
  localparam logic [5:0] ADDR_BIT_DECODE_THRESHOLDS = 6'h1C;
  localparam logic [5:0] ADDR_FIXED_PRESET_E       = 6'h1D;
  localparam logic [5:0] ADDR_RECEIVER_CTRL_B      = 6'h1E;
  localparam logic [5:0] ADDR_QUADRATURE_CLOCK_CTRL = 6'h1F;
  // page 7, write-only analog test selector
  localparam logic [5:0] ADDR_ANALOG_TEST_SELECT   = 6'h3A;

  // page register fields and reset values
  localparam int         PAGING_ENABLE_POS        = 7;
  localparam int         PAGE_NUMBER_LSB          = 0;
  localparam logic [7:0] PAGE_SELECT_RESET        = 8'h80;
  localparam logic [7:0] STORE_RESET              = 8'h00;
  localparam logic [7:0] IRQ_FLAGS_RESET          = 8'h00;
  localparam logic [7:0] COMMAND_IDLE             = 8'h00;
  localparam logic [7:0] WRITE_ONLY_READ_VALUE    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE      = 8'h00;

  // buffer geometry
  localparam int BUFFER_DEPTH = 64;
  localparam int BUFFER_AW    = 6;

  typedef enum logic [2:0] {
    ACC_PAGE   = 3'b000,
    ACC_RW     = 3'b001,
    ACC_DYN    = 3'b010,
    ACC_RO     = 3'b011,
    ACC_WO     = 3'b100,
    ACC_BUFFER = 3'b101,
    ACC_FLAGS  = 3'b110,
    ACC_NONE   = 3'b111
  } access_e;

  // read-only state presented by the internal engines
  typedef struct packed {
    logic [7:0] main_status;
    logic [7:0] extra_status;
    logic [7:0] last_command_errors;
    logic [7:0] collision_bit_index;
    logic [7:0] timer_count_now;
    logic [7:0] checksum_result_low;
    logic [7:0] checksum_result_high;
  } status_s;

  // software settings handed to the internal engines
  typedef struct packed {
    logic [7:0] command_reg;
    logic [7:0] irq_enable_bits;
    logic [7:0] irq_request_flags;
    logic [7:0] control;
    logic [7:0] partial_frame_adjust;
    logic [7:0] antenna_driver_ctrl;
    logic [7:0] driver_conductance;
    logic [7:0] pulse_width_sel;
    logic [7:0] receiver_ctrl_a;
    logic [7:0] decoding_ctrl;
    logic [7:0] rx_tx_phase_sel;
    logic [7:0] bit_decode_thresholds;
    logic [7:0] receiver_ctrl_b;
    logic [7:0] quadrature_clock_ctrl;
    logic [7:0] analog_test_select;
  } config_s;

  // access class of each of the 64 addresses
  function automatic access_e access_of(input logic [5:0] addr);
    access_e cls;
    cls = ACC_NONE;
    if (addr[2:0] == 3'h0) begin
      cls = ACC_PAGE;
    end else if (addr == ADDR_COMMAND_REG || addr == ADDR_CONTROL) begin
      cls = ACC_DYN;
    end else if (addr == ADDR_BUFFER_ACCESS_PORT) begin
      cls = ACC_BUFFER;
    end else if (addr == ADDR_IRQ_REQUEST_FLAGS) begin
      cls = ACC_FLAGS;
    end else if (addr == ADDR_MAIN_STATUS || addr == ADDR_BUFFER_FILL_COUNT || addr == ADDR_EXTRA_STATUS) begin
      cls = ACC_RO;
    end else if (addr >= ADDR_LAST_COMMAND_ERRORS && addr <= ADDR_CHECKSUM_RESULT_HIGH) begin
      cls = ACC_RO;
    end else if (addr == ADDR_IRQ_ENABLE_BITS || addr == ADDR_PARTIAL_FRAME_ADJUST) begin
      cls = ACC_RW;
    end else if (addr > ADDR_PAGE_SELECT_P2 && addr <= ADDR_QUADRATURE_CLOCK_CTRL) begin
      cls = ACC_RW;
    end else if (addr == ADDR_ANALOG_TEST_SELECT) begin
      cls = ACC_WO;
    end
    return cls;
  endfunction : access_of

endpackage : reader_regs_pkg

// File: logic/paged_register_access.sv
// Notes on behaviour
// R1 - six-bit address reaches 64 registers
// R2 - eight pages of eight, top bits page
// R3 - slot zero of every page is page register
// R4 - host writes page before crossing pages
// R5 - dedicated bus: page bits plus three pins
// R6 - muxed paging: page bits plus low lines
// R7 - muxed linear: six lines, page ignored
// R8 - read/write bits untouched by engines
// R9 - dynamic bits: host and engines both write
// R10 - read-only registers ignore host writes
// R11 - write-only registers read back undefined value
// R12 - buffer port: write pushes, read pops
// R13 - fill count reports bytes held
// R14 - interrupt enable and request registers, page 0
// R15 - collision register holds first collision position
// R16 - error register shows last command status
// R17 - host leaves preset registers unchanged
// R18 - host writes expected generic bit values
// R19 - byte-wide registers, one byte per cycle
module paged_register_access (
  input  wire logic                      clk,
  input  wire logic                      rst,
  // host parallel bus
  input  wire logic                      muxed_bus,
  input  wire logic                      addr_latch,
  input  wire logic [2:0]                direct_addr,
  input  wire logic [7:0]                bus_data_in,
  output logic      [7:0]                bus_data_out,
  output logic                           bus_data_oe,
  input  wire logic                      rd_strobe,
  input  wire logic                      wr_strobe,
  // internal engine side
  input  wire reader_regs_pkg::status_s  engine_status,
  input  wire logic                      command_done,
  input  wire logic [7:0]                control_clear,
  input  wire logic [7:0]                irq_events,
  input  wire logic                      engine_push,
  input  wire logic [7:0]                engine_push_data,
  output logic                           engine_push_ready,
  input  wire logic                      engine_pop,
  output logic                           engine_pop_ready,
  output logic      [7:0]                engine_pop_data,
  output reader_regs_pkg::config_s       settings
);

  // address state
  logic [7:0] page_select;
  logic [5:0] muxed_addr;

  // byte store for read/write, dynamic and write-only registers
  logic [7:0] store [0:63];
  logic [7:0] irq_request_flags;

  // buffer state
  logic [7:0] buffer_mem [0:reader_regs_pkg::BUFFER_DEPTH-1];
  logic [reader_regs_pkg::BUFFER_AW-1:0] head_ptr;
  logic [reader_regs_pkg::BUFFER_AW-1:0] tail_ptr;
  logic [reader_regs_pkg::BUFFER_AW:0]   fill;

  // read answer
  logic [7:0] read_hold;
  logic       read_valid;

  // address assembly
  wire logic       paging_enable_bit = page_select[reader_regs_pkg::PAGING_ENABLE_POS];
  wire logic [2:0] page_number_field = page_select[reader_regs_pkg::PAGE_NUMBER_LSB +: 3];
  wire logic [5:0] paged_direct = {page_number_field, direct_addr};   // R5 R4
  wire logic [5:0] paged_muxed  = {page_number_field, muxed_addr[2:0]};   // R6
  wire logic [5:0] reg_addr     = !muxed_bus ? paged_direct :
                                  paging_enable_bit ? paged_muxed : muxed_addr;   // R7 R1 R2

  // access decode
  wire reader_regs_pkg::access_e cls = reader_regs_pkg::access_of(reg_addr);
  wire logic is_page   = (cls == reader_regs_pkg::ACC_PAGE);   // R3
  wire logic is_store  = (cls == reader_regs_pkg::ACC_RW) || (cls == reader_regs_pkg::ACC_DYN) ||
                         (cls == reader_regs_pkg::ACC_WO);
  wire logic is_buffer = (cls == reader_regs_pkg::ACC_BUFFER);
  wire logic is_flags  = (cls == reader_regs_pkg::ACC_FLAGS);
  wire logic is_ro     = (cls == reader_regs_pkg::ACC_RO);
  wire logic is_wo     = (cls == reader_regs_pkg::ACC_WO);

  // host write qualifiers; read-only and unmapped writes fall through
  wire logic host_write_store = wr_strobe && is_store;   // R10
  wire logic host_write_page  = wr_strobe && is_page;
  wire logic host_write_flags = wr_strobe && is_flags;
  wire logic cmd_written      = host_write_store && (reg_addr == reader_regs_pkg::ADDR_COMMAND_REG);
  wire logic ctrl_written     = host_write_store && (reg_addr == reader_regs_pkg::ADDR_CONTROL);

  // buffer handshakes: host takes priority over the engines
  wire logic buf_full       = (fill == 7'(reader_regs_pkg::BUFFER_DEPTH));
  wire logic buf_empty      = (fill == 7'h00);
  wire logic host_push      = wr_strobe && is_buffer && !buf_full;   // R12
  wire logic host_pop       = rd_strobe && is_buffer && !buf_empty;   // R12
  assign engine_push_ready  = !buf_full && !(wr_strobe && is_buffer);
  assign engine_pop_ready   = !buf_empty && !(rd_strobe && is_buffer);
  wire logic do_engine_push = engine_push && engine_push_ready;
  wire logic do_engine_pop  = engine_pop && engine_pop_ready;
  wire logic any_push       = host_push || do_engine_push;
  wire logic any_pop        = host_pop || do_engine_pop;
  wire logic [7:0] push_byte = host_push ? bus_data_in : engine_push_data;
  wire logic [7:0] head_byte = buffer_mem[head_ptr];
  assign engine_pop_data    = head_byte;

  // read-only selection from engine state
  wire logic [7:0] ro_value =
    (reg_addr == reader_regs_pkg::ADDR_MAIN_STATUS)          ? engine_status.main_status :
    (reg_addr == reader_regs_pkg::ADDR_BUFFER_FILL_COUNT)    ? {1'b0, fill} :   // R13
    (reg_addr == reader_regs_pkg::ADDR_EXTRA_STATUS)         ? engine_status.extra_status :
    (reg_addr == reader_regs_pkg::ADDR_LAST_COMMAND_ERRORS)  ? engine_status.last_command_errors :   // R16
    (reg_addr == reader_regs_pkg::ADDR_COLLISION_BIT_INDEX)  ? engine_status.collision_bit_index :   // R15
    (reg_addr == reader_regs_pkg::ADDR_TIMER_COUNT_NOW)      ? engine_status.timer_count_now :
    (reg_addr == reader_regs_pkg::ADDR_CHECKSUM_RESULT_LOW)  ? engine_status.checksum_result_low :
                                                               engine_status.checksum_result_high;

  // read value by class; write-only gives a fixed filler, never the stored byte
  wire logic [7:0] read_value =
    is_page   ? page_select :
    is_wo     ? reader_regs_pkg::WRITE_ONLY_READ_VALUE :   // R11
    is_store  ? store[reg_addr] :   // R8 R9
    is_buffer ? head_byte :
    is_flags  ? irq_request_flags :   // R14
    is_ro     ? ro_value :   // R10
                reader_regs_pkg::UNMAPPED_READ_VALUE;

  // address latch for the multiplexed bus, low six lines only
  always_ff @(posedge clk) begin
    if (rst) begin
      muxed_addr <= 6'h00;
    end else if (muxed_bus && addr_latch) begin
      muxed_addr <= bus_data_in[5:0];   // R7
    end
  end

  // page register shared by all eight page slots
  always_ff @(posedge clk) begin
    if (rst) begin
      page_select <= reader_regs_pkg::PAGE_SELECT_RESET;
    end else if (host_write_page) begin
      page_select <= bus_data_in;   // R3 R19
    end
  end

  // byte store; engines only touch the two dynamic registers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 64; i++) begin
        store[i] <= reader_regs_pkg::STORE_RESET;
      end
    end else begin
      if (host_write_store) begin
        store[reg_addr] <= bus_data_in;   // R8 R19
      end
      // a fresh host command outranks the completion of the old one
      if (command_done && !cmd_written) begin
        store[reader_regs_pkg::ADDR_COMMAND_REG] <= reader_regs_pkg::COMMAND_IDLE;   // R9
      end
      if ((|control_clear) && !ctrl_written) begin
        store[reader_regs_pkg::ADDR_CONTROL] <= store[reader_regs_pkg::ADDR_CONTROL] & ~control_clear;   // R9
      end
    end
  end

  // request flags: engines set, host writes ones to clear, a set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_request_flags <= reader_regs_pkg::IRQ_FLAGS_RESET;
    end else begin
      irq_request_flags <= (irq_request_flags & ~(host_write_flags ? bus_data_in : 8'h00)) | irq_events;   // R14
    end
  end

  // buffer storage, written only on an accepted push
  always_ff @(posedge clk) begin
    if (any_push) begin
      buffer_mem[tail_ptr] <= push_byte;   // R12
    end
  end

  // buffer pointers and count; push and pop may meet in one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      head_ptr <= '0;
      tail_ptr <= '0;
      fill     <= '0;
    end else begin
      if (any_push) begin
        tail_ptr <= tail_ptr + 6'h01;
      end
      if (any_pop) begin
        head_ptr <= head_ptr + 6'h01;
      end
      if (any_push && !any_pop) begin
        fill <= fill + 7'h01;   // R13
      end else if (any_pop && !any_push) begin
        fill <= fill - 7'h01;   // R13
      end
    end
  end

  // read answer: captured on the strobe, driven the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      read_hold  <= 8'h00;
      read_valid <= 1'b0;
    end else begin
      read_valid <= rd_strobe;
      if (rd_strobe) begin
        read_hold <= read_value;   // R19
      end
    end
  end

  assign bus_data_out = read_hold;
  assign bus_data_oe  = read_valid;

  // settings view for the engines; presets are kept but not exported
  assign settings.command_reg           = store[reader_regs_pkg::ADDR_COMMAND_REG];
  assign settings.irq_enable_bits       = store[reader_regs_pkg::ADDR_IRQ_ENABLE_BITS];   // R14
  assign settings.irq_request_flags     = irq_request_flags;
  assign settings.control               = store[reader_regs_pkg::ADDR_CONTROL];
  assign settings.partial_frame_adjust  = store[reader_regs_pkg::ADDR_PARTIAL_FRAME_ADJUST];
  assign settings.antenna_driver_ctrl   = store[reader_regs_pkg::ADDR_ANTENNA_DRIVER_CTRL];
  assign settings.driver_conductance    = store[reader_regs_pkg::ADDR_DRIVER_CONDUCTANCE];
  assign settings.pulse_width_sel       = store[reader_regs_pkg::ADDR_PULSE_WIDTH_SEL];
  assign settings.receiver_ctrl_a       = store[reader_regs_pkg::ADDR_RECEIVER_CTRL_A];
  assign settings.decoding_ctrl         = store[reader_regs_pkg::ADDR_DECODING_CTRL];
  assign settings.rx_tx_phase_sel       = store[reader_regs_pkg::ADDR_RX_TX_PHASE_SEL];
  assign settings.bit_decode_thresholds = store[reader_regs_pkg::ADDR_BIT_DECODE_THRESHOLDS];
  assign settings.receiver_ctrl_b       = store[reader_regs_pkg::ADDR_RECEIVER_CTRL_B];
  assign settings.quadrature_clock_ctrl = store[reader_regs_pkg::ADDR_QUADRATURE_CLOCK_CTRL];
  assign settings.analog_test_select    = store[reader_regs_pkg::ADDR_ANALOG_TEST_SELECT];   // R11

endmodule : paged_register_access

// File: tb/paged_register_access_assertions.sv
module paged_register_access_assertions (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     rd_strobe,
  input wire logic                     wr_strobe,
  input wire logic [7:0]               bus_data_out,
  input wire logic                     bus_data_oe,
  input wire logic                     command_done,
  input wire logic [7:0]               control_clear,
  input wire logic [7:0]               irq_events,
  input wire reader_regs_pkg::config_s settings
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // nothing that may touch a setting is active
  sequence s_quiet;
    !wr_strobe && !command_done && control_clear == 8'h00 && irq_events == 8'h00;
  endsequence
  sequence s_read_req;
    rd_strobe && !wr_strobe;
  endsequence
  a_read_answer_next: assert property (s_read_req |=> bus_data_oe)
    else $error("read not answered in the next cycle");
  a_answer_has_cause: assert property (bus_data_oe |-> $past(rd_strobe))
    else $error("read enable without a read strobe");
  a_answer_one_cycle: assert property (s_read_req ##1 !rd_strobe |=> !bus_data_oe)
    else $error("read enable stands too long");
  a_read_data_holds: assert property (!rd_strobe |=> $stable(bus_data_out))
    else $error("read data moved without a read");
  a_command_done_idle: assert property (command_done && !wr_strobe |=> settings.command_reg == 8'h00)
    else $error("command register not idle after completion");
  a_event_sets_flag: assert property (irq_events != 8'h00 |=>
    (settings.irq_request_flags & $past(irq_events)) == $past(irq_events))
    else $error("event did not set its request flag");
  a_control_cleared: assert property (control_clear != 8'h00 && !wr_strobe |=>
    (settings.control & $past(control_clear)) == 8'h00)
    else $error("control bits not cleared by engine");
  a_quiet_settings: assert property (s_quiet |=> $stable(settings))
    else $error("setting changed without a cause");
endmodule : paged_register_access_assertions

bind paged_register_access paged_register_access_assertions u_checker (.clk(clk), .rst(rst),
  .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
  .command_done(command_done), .control_clear(control_clear), .irq_events(irq_events), .settings(settings));

// File: tb/host_bus_model.sv
module host_bus_model (
  input  wire logic       clk,
  input  wire logic [7:0] bus_data_out,
  input  wire logic       bus_data_oe,
  output logic            muxed_bus,
  output logic            addr_latch,
  output logic [2:0]      direct_addr,
  output logic [7:0]      bus_data_in,
  output logic            rd_strobe,
  output logic            wr_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] page = 3'h0;
  logic       paging = 1'b1;
  // idle bus at time zero
  initial begin
    muxed_bus = 1'b0;
    addr_latch = 1'b0;
    direct_addr = 3'h0;
    bus_data_in = 8'h00;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
  end
  // one byte per strobe; released lines flip so no stale value looks valid
  task automatic bus_cycle(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    if (muxed_bus) begin
      addr_latch <= 1'b1;
      bus_data_in <= {2'b00, a};
      @(posedge clk);
      addr_latch <= 1'b0;
    end
    direct_addr <= a[2:0];
    bus_data_in <= d;
    rd_strobe <= !wr;
    wr_strobe <= wr;
    @(posedge clk);
    rd_strobe <= 1'b0;
    wr_strobe <= 1'b0;
    bus_data_in <= ~d;
    direct_addr <= ~a[2:0];
    #1;
    q = bus_data_out;
  endtask : bus_cycle
  // page register moved first whenever a target off slot zero lies in another page, unless the muxed bus runs linear
  task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] unused;
    if ((paging || !muxed_bus) && a[2:0] != 3'h0 && a[5:3] != page) begin
      bus_cycle(1'b1, {page, 3'h0}, {1'b1, 4'h0, a[5:3]}, unused);
      page = a[5:3];
    end
    bus_cycle(wr, a, d, q);
  endtask : acc
  task automatic set_mode(input logic mux, input logic pg_on, input logic [2:0] pg);
    logic [7:0] unused;
    @(posedge clk);
    muxed_bus <= mux;
    bus_cycle(1'b1, {pg, 3'h0}, {pg_on, 4'h0, pg}, unused);
    page = pg;
    paging = pg_on;
  endtask : set_mode
endmodule : host_bus_model

// File: tb/paged_register_access_tb.sv
module paged_register_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       muxed_bus, addr_latch, rd_strobe, wr_strobe, bus_data_oe, engine_push_ready, engine_pop_ready;
  logic       command_done = 1'b0, engine_push = 1'b0, engine_pop = 1'b0;
  logic [2:0] direct_addr;
  logic [7:0] bus_data_in, bus_data_out, engine_pop_data;
  logic [7:0] control_clear = 8'h00, irq_events = 8'h00, engine_push_data = 8'h00;
  reader_regs_pkg::status_s engine_status = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77};
  reader_regs_pkg::config_s settings;
  int         fails = 0;
  int         checks_done = 0;
  always #20 clk = ~clk;
  paged_register_access DUT (.clk(clk), .rst(rst), .muxed_bus(muxed_bus), .addr_latch(addr_latch),
    .direct_addr(direct_addr), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .engine_status(engine_status), .command_done(command_done),
    .control_clear(control_clear), .irq_events(irq_events), .engine_push(engine_push),
    .engine_push_data(engine_push_data), .engine_push_ready(engine_push_ready), .engine_pop(engine_pop),
    .engine_pop_ready(engine_pop_ready), .engine_pop_data(engine_pop_data), .settings(settings));
  host_bus_model host (.clk(clk), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .muxed_bus(muxed_bus),
    .addr_latch(addr_latch), .direct_addr(direct_addr), .bus_data_in(bus_data_in), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe));
  task automatic end_of_test;
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.acc(1'b0, a, 8'h00, q);
    cmp8(q, exp);
  endtask : rd_chk
  // plain storage across pages 0..3, then page slot seen from page 3
  // presets are left alone, as host software must keep them
  task automatic t_rw;
    logic [5:0] adr [8] = '{6'h06, 6'h0F, 6'h11, 6'h12, 6'h1A, 6'h15, 6'h1C, 6'h1F};
    rd_chk(6'h00, reader_regs_pkg::PAGE_SELECT_RESET);
    for (int i = 0; i < 8; i++) wr(adr[i], 8'hA0 + 8'(i));
    for (int i = 0; i < 8; i++) rd_chk(adr[i], 8'hA0 + 8'(i));
    rd_chk(6'h08, 8'h83);
    cmp8(settings.quadrature_clock_ctrl, 8'hA7);
  endtask : t_rw
  // host writes bounce off engine state
  task automatic t_ro;
    logic [5:0] adr [7] = '{6'h03, 6'h05, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E};
    for (int i = 0; i < 7; i++) wr(adr[i], 8'hFF);
    for (int i = 0; i < 7; i++) rd_chk(adr[i], 8'h11 * 8'(i + 1));
    wr(6'h3A, 8'h5A);
    cmp8(settings.analog_test_select, 8'h5A);
    rd_chk(6'h3A, reader_regs_pkg::WRITE_ONLY_READ_VALUE);
    wr(6'h33, 8'hC3);
    rd_chk(6'h33, reader_regs_pkg::UNMAPPED_READ_VALUE);
  endtask : t_ro
  // engine completion and clear masks, request flags
  task automatic t_dyn;
    wr(6'h01, 8'h0C);
    cmp8(settings.command_reg, 8'h0C);
    wr(6'h09, 8'hF0);
    @(posedge clk);
    command_done <= 1'b1;
    control_clear <= 8'h30;
    irq_events <= 8'h05;
    @(posedge clk);
    command_done <= 1'b0;
    control_clear <= 8'h00;
    irq_events <= 8'h00;
    rd_chk(6'h01, reader_regs_pkg::COMMAND_IDLE);
    rd_chk(6'h09, 8'hC0);
    rd_chk(6'h07, 8'h05);
    wr(6'h07, 8'h01);
    rd_chk(6'h07, 8'h04);
  endtask : t_dyn
  // order through the port, engine pop and push, fill to refusal and drain
  task automatic t_buffer;
    for (int i = 0; i < 3; i++) wr(6'h02, 8'hA1 + 8'(i));
    rd_chk(6'h04, 8'h03);
    rd_chk(6'h02, 8'hA1);
    rd_chk(6'h02, 8'hA2);
    cmp8({7'h00, engine_pop_ready}, 8'h01);
    cmp8(engine_pop_data, 8'hA3);
    @(posedge clk);
    engine_pop <= 1'b1;
    @(posedge clk);
    engine_pop <= 1'b0;
    engine_push <= 1'b1;
    engine_push_data <= 8'h5C;
    @(posedge clk);
    engine_push <= 1'b0;
    rd_chk(6'h02, 8'h5C);
    for (int i = 0; i < 65; i++) wr(6'h02, 8'(i));
    rd_chk(6'h04, 8'h40);
    cmp8({7'h00, engine_push_ready}, 8'h00);
    for (int i = 0; i < 64; i++) rd_chk(6'h02, 8'(i));
    rd_chk(6'h04, 8'h00);
  endtask : t_buffer
  // muxed paging, then linear with page bits pointing elsewhere
  task automatic t_muxed;
    host.set_mode(1'b1, 1'b1, 3'h0);
    wr(6'h19, 8'h6B);
    cmp8(settings.receiver_ctrl_a, 8'h6B);
    host.set_mode(1'b1, 1'b0, 3'h5);
    wr(6'h0F, 8'h3E);
    cmp8(settings.partial_frame_adjust, 8'h3E);
    rd_chk(6'h1E, 8'h00);
    rd_chk(6'h00, 8'h05);
  endtask : t_muxed
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_rw();
    t_ro();
    t_dyn();
    t_buffer();
    t_muxed();
    end_of_test();
  end
  // whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule : paged_register_access_tb
